//--- src/clock_startup_pkg.sv
// Purpose: constants for clock source selection and start-up timing
// Assumes: configuration settings arrive as static levels
// Notes: settings use "0" for programmed, "1" for unprogrammed
// Behaviour
// - crystal band from upper three select bits: 100,101,110,111.
// - crystal group0, start-up 00/01: 258 cycles; reset +4.1/65 ms.
// - 1K-cycle wait for group0 10/11 and group1 00.
// - crystal group 1 with 01/10/11: 16K cycles wait.
// - RC 4 MHz for codes 0010-0011, 8 MHz for 0100-0101.
// - divide-by-eight setting delivered programmed.
// - every reset copies factory calibration bits 6..0 into trim register, bit 7 cleared.
// - watchdog oscillator still times watchdog and reset time-out.
// - RC source: 6-cycle wake-up; reset adds 14, +4.1 ms, +65 ms.
// - trim value is seven bits 6..0; larger values raise frequency.
// - trimmed frequency range spans 50 to 200 percent of nominal.
// - extra reset delays are 512 or 8192 watchdog cycles.
// - divider resets to 0011 if divide-by-eight programmed, else 0000.
package clock_startup_pkg;
  localparam logic [2:0] band_low = 3'h4;
  localparam logic [2:0] band_mid = 3'h5;
  localparam logic [2:0] band_high = 3'h6;
  localparam logic [2:0] band_top = 3'h7;
  localparam logic [3:0] sel_rc4_a = 4'h2;
  localparam logic [3:0] sel_rc4_b = 4'h3;
  localparam logic [3:0] sel_rc8_a = 4'h4;
  localparam logic [3:0] sel_rc8_b = 4'h5;
  localparam logic [3:0] sel_default = 4'h4;
  localparam logic [1:0] sut_default = 2'h2;
  localparam logic div8_default = 1'h0;
  localparam logic [15:0] ck_258 = 16'h0102;
  localparam logic [15:0] ck_1k = 16'h0400;
  localparam logic [15:0] ck_16k = 16'h4000;
  localparam logic [15:0] ck_6 = 16'h0006;
  localparam logic [15:0] ck_14 = 16'h000e;
  localparam logic [15:0] wdt_short = 16'h0200;
  localparam logic [15:0] wdt_long = 16'h2000;
  localparam logic [3:0] div_by_eight = 4'h3;
  localparam logic [3:0] div_by_one = 4'h0;
  localparam int trim_width = 7;
  localparam int trim_msb = 6;
  typedef enum logic [2:0] {
    st_reset = 3'b000,
    st_osc = 3'b001,
    st_wdt = 3'b010,
    st_fourteen = 3'b011,
    st_run = 3'b100,
    st_halt = 3'b101
  } phase_type;
  typedef enum logic [1:0] {
    src_ext = 2'b00,
    src_rc = 2'b01,
    src_xtal = 2'b10,
    src_other = 2'b11
  } source_type;
endpackage

//--- src/clock_source_startup_calib.sv
// Purpose: picks clock source, times start-up, holds rc trim register
// Assumes: mclk is the selected oscillator; watchdog ticks come from a pin
// Notes: oscillator amplifier itself is analog and lives outside
`timescale 1ns/100ps
module clock_source_startup_calib
  import clock_startup_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] clock_source_select_setting,
  input wire logic [1:0] startup_time_setting,
  input wire logic divide_by_eight_setting,
  input wire logic [7:0] factory_calibration_byte,
  input wire logic wake_request,
  input wire logic watchdog_osc_tick,
  input wire logic trim_write,
  input wire logic [7:0] trim_write_data,
  output logic [7:0] rc_oscillator_trim,
  output logic [3:0] system_divider_select,
  output logic rc_select,
  output logic rc_8mhz,
  output logic crystal_enable,
  output logic [2:0] crystal_band_select,
  output logic startup_group_select,
  output logic cpu_run,
  output logic config_reserved
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic source_type decode_source(input logic [3:0] sel);
    if (sel[3])
      decode_source = src_xtal;
    else if (sel == sel_rc4_a || sel == sel_rc4_b ||
             sel == sel_rc8_a || sel == sel_rc8_b)
      decode_source = src_rc;
    else if (sel == 4'h0)
      decode_source = src_ext;
    else
      decode_source = src_other;
  endfunction

  // wake-up count in oscillator cycles
  function automatic logic [15:0] osc_count(input logic [3:0] sel,
                                            input logic [1:0] sut);
    logic [2:0] code;
    code = {sel[0], sut};
    if (!sel[3])
      osc_count = ck_6;
    else if (code == 3'h0 || code == 3'h1)
      osc_count = ck_258;
    else if (code == 3'h2 || code == 3'h3 || code == 3'h4)
      osc_count = ck_1k;
    else
      osc_count = ck_16k;
  endfunction

  // watchdog-timed reset delay: 0 none, else cycle count
  function automatic logic [15:0] wdt_count(input logic [3:0] sel,
                                            input logic [1:0] sut);
    logic [1:0] step;
    step = sel[3] ? 2'(({1'b0, sut} + 3'(sel[0] ? 3'h2 : 3'h1)) % 3)
                  : sut;
    case (step)
      2'h1: wdt_count = wdt_short;
      2'h2: wdt_count = wdt_long;
      default: wdt_count = 16'h0000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // watchdog tick synchroniser
  // ------------------------------------------------------------
  logic [2:0] tick_sync_reg;
  logic [2:0] tick_sync_next;
  logic tick_level_reg;
  logic tick_level_next;
  logic tick_edge;
  always_comb
  begin
    tick_sync_next = {tick_sync_reg[1:0], watchdog_osc_tick};
    tick_level_next = tick_level_reg;
    // a level counts only once stages 1 and 2 agree
    if (tick_sync_reg[1] == tick_sync_reg[2])
      tick_level_next = tick_sync_reg[2];
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tick_sync_reg <= 3'h0;
      tick_level_reg <= 1'b0;
    end
    else
    begin
      tick_sync_reg <= tick_sync_next;
      tick_level_reg <= tick_level_next;
    end
  end
  // stage 0 feeds only stage 1; edge is taken from the agreed later stages
  assign tick_edge = tick_sync_reg[1] & tick_sync_reg[2] & ~tick_level_reg;

  // ------------------------------------------------------------
  // start-up sequencer
  // ------------------------------------------------------------
  phase_type phase_reg;
  phase_type phase_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] trim_reg;
  logic [7:0] trim_next;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic run_reg;
  logic run_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic [1:0] sut_reg;
  logic [1:0] sut_next;
  logic [15:0] wdt_need;

  assign wdt_need = wdt_count(sel_reg, sut_reg);

  always_comb
  begin
    phase_next = phase_reg;
    count_next = count_reg;
    trim_next = trim_reg;
    div_next = div_reg;
    run_next = 1'b0;
    sel_next = sel_reg;
    sut_next = sut_reg;
    case (phase_reg)
      st_reset:
      begin
        // settings and calibration are caught after release, never async
        sel_next = clock_source_select_setting;
        sut_next = startup_time_setting;
        trim_next = {1'b0, factory_calibration_byte[trim_msb:0]};
        div_next = divide_by_eight_setting ? div_by_one
                                           : div_by_eight;
        count_next = 16'h0000;
        phase_next = st_fourteen;
      end
      st_fourteen:
      begin
        // reset adds 14 oscillator cycles before the watchdog delay
        if (count_reg == ck_14 - 16'h0001)
        begin
          count_next = 16'h0000;
          phase_next = st_wdt;
        end
        else
          count_next = count_reg + 16'h0001;
      end
      st_wdt:
      begin
        // watchdog oscillator times the reset delay even on rc clock
        if (count_reg >= wdt_need)
        begin
          count_next = 16'h0000;
          phase_next = st_run;
        end
        else if (tick_edge)
          count_next = count_reg + 16'h0001;
      end
      st_run:
      begin
        run_next = 1'b1;
        if (wake_request)
        begin
          run_next = 1'b0;
          count_next = 16'h0000;
          phase_next = st_osc;
        end
      end
      st_osc:
      begin
        // wake from power-down: count oscillator cycles only
        if (count_reg == osc_count(sel_reg, sut_reg) - 16'h0001)
        begin
          run_next = 1'b1;
          phase_next = st_run;
        end
        else
          count_next = count_reg + 16'h0001;
      end
      default:
      begin
        phase_next = st_reset;
      end
    endcase
    if (trim_write && phase_reg != st_reset)
      trim_next = {1'b0, trim_write_data[trim_msb:0]};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg <= st_reset;
      count_reg <= 16'h0000;
      trim_reg <= 8'h00;
      div_reg <= div_by_eight;
      run_reg <= 1'b0;
      sel_reg <= sel_default;
      sut_reg <= sut_default;
    end
    else
    begin
      phase_reg <= phase_next;
      count_reg <= count_next;
      trim_reg <= trim_next;
      div_reg <= div_next;
      run_reg <= run_next;
      sel_reg <= sel_next;
      sut_reg <= sut_next;
    end
  end

  // ------------------------------------------------------------
  // registered decode outputs
  // ------------------------------------------------------------
  logic [4:0] dec_reg;
  logic [4:0] dec_next;
  logic [2:0] band_reg;
  logic [2:0] band_next;
  source_type src;
  always_comb
  begin
    src = decode_source(sel_reg);
    band_next = sel_reg[3:1];
    dec_next[0] = (src == src_rc);
    dec_next[1] = (src == src_rc) && sel_reg[2];
    dec_next[2] = (src == src_xtal);
    dec_next[3] = (src == src_other) ||
                  ((src == src_rc) && sut_reg == 2'h3);
    dec_next[4] = sel_reg[0];
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dec_reg <= 5'h00;
      band_reg <= band_low;
    end
    else
    begin
      dec_reg <= dec_next;
      band_reg <= band_next;
    end
  end

  assign rc_oscillator_trim = trim_reg;
  assign system_divider_select = div_reg;
  assign cpu_run = run_reg;
  assign rc_select = dec_reg[0];
  assign rc_8mhz = dec_reg[1];
  assign crystal_enable = dec_reg[2];
  assign config_reserved = dec_reg[3];
  assign startup_group_select = dec_reg[4];
  assign crystal_band_select = band_reg;
endmodule

//--- test/clock_startup_checker.sv
// Purpose: port checks for clock source and start-up block
// Assumes: settings held steady while cpu_run is high
// Notes: one clock domain, reset disables all checks
`timescale 1ns/100ps
module clock_startup_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] clock_source_select_setting,
  input wire logic divide_by_eight_setting,
  input wire logic [7:0] factory_calibration_byte,
  input wire logic wake_request,
  input wire logic trim_write,
  input wire logic [7:0] trim_write_data,
  input wire logic [7:0] rc_oscillator_trim,
  input wire logic [3:0] system_divider_select,
  input wire logic rc_select,
  input wire logic crystal_enable,
  input wire logic [2:0] crystal_band_select,
  input wire logic cpu_run
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_t7; rc_oscillator_trim[7] == 1'b0; endproperty
  a_t7: assert property (p_t7) else $error("trim bit 7 set");
  property p_twr; cpu_run && trim_write |=>
    rc_oscillator_trim[6:0] == $past(trim_write_data[6:0]); endproperty
  a_twr: assert property (p_twr) else $error("trim write lost");
  property p_load; $fell(rst) |=>
    rc_oscillator_trim == {1'b0, factory_calibration_byte[6:0]}; endproperty
  a_load: assert property (p_load) else $error("trim not loaded");
  property p_div; $fell(rst) |=> system_divider_select ==
    (divide_by_eight_setting ? 4'h0 : 4'h3); endproperty
  a_div: assert property (p_div) else $error("divider reset");
  property p_rc; cpu_run |-> rc_select ==
    (clock_source_select_setting[3:1] inside {3'h1, 3'h2}); endproperty
  a_rc: assert property (p_rc) else $error("rc decode");
  property p_band; cpu_run && clock_source_select_setting[3] |->
    crystal_enable && crystal_band_select ==
    clock_source_select_setting[3:1]; endproperty
  a_band: assert property (p_band) else $error("band decode");
  property p_wake; cpu_run && wake_request |=> !cpu_run; endproperty
  a_wake: assert property (p_wake) else $error("no halt on wake");
  property p_six; $fell(cpu_run) && rc_select |->
    !cpu_run [*5] ##[1:4] cpu_run; endproperty
  a_six: assert property (p_six) else $error("rc wake count");
endmodule
bind clock_source_startup_calib clock_startup_checker u_chk (.mclk, .rst,
  .clock_source_select_setting, .divide_by_eight_setting,
  .factory_calibration_byte, .wake_request, .trim_write, .trim_write_data,
  .rc_oscillator_trim, .system_divider_select, .rc_select, .crystal_enable,
  .crystal_band_select, .cpu_run);

//--- test/osc_partner.sv
// Purpose: slow free-running oscillator feeding reset time-out ticks
// Assumes: period of four system clocks
// Notes: never stops, so no idle level applies
`timescale 1ns/100ps
module osc_partner (
  output logic tick
);
  initial tick = 1'b0;
  // keeps running whichever source is chosen
  always #20 tick = ~tick;
endmodule

//--- test/test_clock_source_startup_calib.sv
// Purpose: boots ten select/start-up settings, checks decodes, delays, trim register
// Assumes: watchdog tick period is 4 mclk cycles
// Notes: delay counts checked with a small sync allowance
`timescale 1ns/100ps
module test_clock_source_startup_calib;
  import clock_startup_pkg::*;
  logic mclk = 0, rst = 1, div8 = 0, wake = 0, twr = 0, tick;
  logic [3:0] sel = 4'h4, divsel;
  logic [1:0] sut = 2'h0;
  logic [7:0] fac = 8'h00, twd = 8'h00, trim;
  logic rc, rc8, xen, grp, run, resv;
  logic [2:0] band;
  int n_fail = 0, checked = 0;
  always #5 mclk = ~mclk;
  osc_partner wd (.tick(tick));
  clock_source_startup_calib dut (.mclk(mclk), .rst(rst),
    .clock_source_select_setting(sel), .startup_time_setting(sut),
    .divide_by_eight_setting(div8), .factory_calibration_byte(fac),
    .wake_request(wake), .watchdog_osc_tick(tick), .trim_write(twr),
    .trim_write_data(twd), .rc_oscillator_trim(trim),
    .system_divider_select(divsel), .rc_select(rc), .rc_8mhz(rc8),
    .crystal_enable(xen), .crystal_band_select(band),
    .startup_group_select(grp), .cpu_run(run), .config_reserved(resv));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wait_run(output int c);
    c = 0;
    while (run !== 1'b1 && c < 40000)
    begin
      @(posedge mclk);
      #1 c++;
    end
  endtask
  task cfg(input logic [3:0] s, input logic [1:0] u, input int n, e);
    int c;
    @(posedge mclk);
    #1 rst = 1;
    div8 = s[0] && s[3:1] != 3'h2;
    {sel, sut, fac} = {s, u, s, 2'h2, u};
    repeat (6) @(posedge mclk);
    #1 rst = 0;
    wait_run(c);
    chk(c >= 10 + 4 * e && c <= 30 + 4 * e, 1);
    chk(trim, {1'b0, fac[6:0]});
    chk(divsel, div8 ? 4'h0 : 4'h3);
    chk({rc, rc8}, {s[3:1] inside {1, 2}, s[3:1] == 2});
    chk({xen, band, grp}, {s[3], s});
    chk(resv, !s[3] && u == 2'h3);
    wake = 1;
    @(posedge mclk);
    #1 wake = 0;
    wait_run(c);
    chk(c >= n - 1 && c <= n + 2, 1);
    $display("test done sel %h sut %h", s, u);
  endtask
  initial
  begin
    cfg(4'h4, 2'h0, 6, 0);
    @(posedge mclk);
    #1 {twr, twd} = {1'b1, 8'he8};
    @(posedge mclk);
    #1 chk(trim, 8'h68);
    twd = 8'h52;
    @(posedge mclk);
    #1 twr = 0;
    chk(trim, 8'h52);
    $display("test done trim writes");
    cfg(4'h2, 2'h1, 6, 512);
    cfg(4'h3, 2'h2, 6, 8192);
    cfg(4'h5, 2'h3, 6, 0);
    cfg(4'h8, 2'h0, 258, 512);
    cfg(4'ha, 2'h2, 1024, 0);
    cfg(4'hd, 2'h1, 16384, 0);
    cfg(4'hf, 2'h2, 16384, 512);
    cfg(4'hc, 2'h3, 1024, 512);
    cfg(4'h0, 2'h0, 6, 0);
    wrap_up;
  end
  initial
  begin
    #900000;
    n_fail++;
    wrap_up;
  end
endmodule
